// *** scc_pkg.sv ***
package scc_pkg;
  // Pixel clock rate
  localparam int CLK_MHZ = 100;
  // Vsync pin idle time before the separator takes over
  localparam int VS_IDLE_MS = 50;
  localparam int VS_IDLE_CYC = VS_IDLE_MS * 1000 * CLK_MHZ;
  // Register indices, byte address is four times the index
  localparam logic [5:0] IDX_HCTL = 6'h12;
  localparam logic [5:0] IDX_HLEN = 6'h13;
  localparam logic [5:0] IDX_VCTL = 6'h14;
  localparam logic [5:0] IDX_VLEN = 6'h15;
  localparam logic [5:0] IDX_PRE = 6'h16;
  localparam logic [5:0] IDX_POST = 6'h17;
  localparam logic [5:0] IDX_CCTL = 6'h18;
  localparam logic [5:0] IDX_STAT = 6'h1f;
  // Hsync control field
  localparam int HCTL_OPOL = 3;
  // Vsync control fields
  localparam int VCTL_SOVR = 7;
  localparam int VCTL_SRC = 6;
  localparam int VCTL_POVR = 5;
  localparam int VCTL_IPOL = 4;
  localparam int VCTL_OPOL = 3;
  localparam int VCTL_FILT = 2;
  localparam int VCTL_DEN = 1;
  // Hold and clamp control fields
  localparam int CCTL_CSRC = 7;
  localparam int CCTL_POVR = 6;
  localparam int CCTL_IPOL = 5;
  localparam int CCTL_CLSRC = 4;
  localparam int CCTL_RED = 3;
  localparam int CCTL_GRN = 2;
  // Reset values
  localparam logic [7:0] HCTL_RST = 8'h08;
  localparam logic [7:0] HLEN_RST = 8'h20;
  localparam logic [7:0] VCTL_RST = 8'h18;
  localparam logic [7:0] VLEN_RST = 8'h0a;
  localparam logic [7:0] PRE_RST = 8'h00;
  localparam logic [7:0] POST_RST = 8'h00;
  localparam logic [7:0] CCTL_RST = 8'h20;
  // Writable bit masks
  localparam logic [7:0] HCTL_MASK = 8'h08;
  localparam logic [7:0] VCTL_MASK = 8'hfe;
  localparam logic [7:0] CCTL_MASK = 8'hfc;
  // Internal clamp timing defaults
  localparam logic [7:0] CLAMP_PLACE_DEF = 8'h08;
  localparam logic [7:0] CLAMP_DUR_DEF = 8'h14;
  // Synchroniser lanes
  localparam int PIN_VS = 0;
  localparam int PIN_SEP = 1;
  localparam int PIN_HOLD = 2;
  localparam int PIN_CLMP = 3;
endpackage : scc_pkg

// *** scc_sync_ctrl.sv ***
`timescale 1ns/1ps
module scc_sync_ctrl
  import scc_pkg::*;
#(
  parameter int VS_IDLE = VS_IDLE_CYC,
  parameter int CNT_W = 24,
  parameter int LINE_W = 12,
  parameter logic [7:0] CLAMP_PLACE = CLAMP_PLACE_DEF,
  parameter logic [7:0] CLAMP_DUR = CLAMP_DUR_DEF,
  parameter logic CLAMP_EXT_HIGH = 1'b1,
  parameter logic HOLD_AUTO_HIGH = 1'b1
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic line_strobe_i,
  input wire logic vsync_pin_i,
  input wire logic sep_vsync_i,
  input wire logic hold_pin_i,
  input wire logic clamp_pin_i,
  output logic hsync_o,
  output logic vsync_o,
  output logic coast_o,
  output logic clamp_o,
  output logic red_mid_o,
  output logic green_mid_o
);

  // Whole block state
  typedef struct packed {
    logic [3:0] m1; // First synchroniser stage
    logic [3:0] m2; // Second synchroniser stage
    logic wreq; // Bus waitrequest
    logic [7:0] rdata; // Read data
    logic [7:0] hctl; // Hsync control
    logic [7:0] hlen; // Hsync pulse length
    logic [7:0] vctl; // Vsync control
    logic [7:0] vlen; // Vsync pulse length
    logic [7:0] pre; // Lines held before vsync
    logic [7:0] post; // Lines held after vsync
    logic [7:0] cctl; // Hold and clamp control
    logic pinp; // Previous vsync pin level
    logic [CNT_W-1:0] idle; // Cycles since pin edge
    logic vprev; // Previous selected vsync
    logic [CNT_W-1:0] run; // Current level run
    logic [CNT_W-1:0] hi_len; // Last high run
    logic [CNT_W-1:0] lo_len; // Last low run
    logic vf; // Filtered active vsync
    logic vfp; // Previous filtered vsync
    logic vout; // Vsync after duration stage
    logic [7:0] vdc; // Duration lines left
    logic [LINE_W-1:0] lcnt; // Lines since vsync lead
    logic [LINE_W-1:0] flines; // Lines in last frame
    logic [7:0] pcnt; // Post hold lines left
    logic hs_act; // Hsync pulse active
    logic [7:0] hcnt; // Hsync pulse counter
    logic [8:0] ccnt; // Pixels since line strobe
    logic hs; // Hsync output
    logic vs; // Vsync output
    logic coast; // Hold output
    logic clamp; // Clamp output
  } scc_state_t;

  scc_state_t q; // Current state
  scc_state_t n; // Next state

  // Bus decode
  logic req; // Any request
  logic [5:0] idx; // Register index
  logic wr_en; // Write takes effect
  assign req = avs_read_i | avs_write_i;
  assign idx = avs_address_i[7:2];
  assign wr_en = avs_write_i & ~q.wreq & avs_byteenable_i[0];

  // Synchronised pins
  logic pin; // Vsync pin
  logic sep; // Separator vsync
  logic hold; // Hold pin
  logic cpin; // Clamp pin
  assign pin = q.m2[PIN_VS];
  assign sep = q.m2[PIN_SEP];
  assign hold = q.m2[PIN_HOLD];
  assign cpin = q.m2[PIN_CLMP];

  // Vsync source and polarity
  logic alive; // Pin shows activity
  logic vsel; // Selected vsync
  logic auto_high; // Detected active-high
  logic phigh; // Polarity in use
  logic vact; // Vsync as active-high
  assign alive = q.idle != CNT_W'(VS_IDLE);
  // Override picks pin or separator, else live pin wins
  assign vsel = q.vctl[VCTL_SOVR] ? (q.vctl[VCTL_SRC] ? sep : pin)
                                  : (alive ? pin : sep);
  // Shorter level is the active one
  assign auto_high = q.hi_len < q.lo_len;
  assign phigh = q.vctl[VCTL_POVR] ? q.vctl[VCTL_IPOL] : auto_high;
  assign vact = phigh ? vsel : ~vsel;

  // Vsync edges after the filter
  logic vlead; // Leading edge
  logic vtrail; // Trailing edge
  assign vlead = q.vf & ~q.vfp;
  assign vtrail = ~q.vf & q.vfp;

  // Hold window terms
  logic pre_on; // Inside precoast window
  logic icoast; // Internal hold
  logic hpol; // Hold pin polarity
  logic xcoast; // External hold
  // Window only meaningful once precoast is nonzero and a frame length has been measured
  assign pre_on = (q.pre != 8'h00) && (q.flines != '0) &&
                  (({1'b0, q.lcnt} + (LINE_W + 1)'(q.pre)) >= {1'b0, q.flines});
  // Trailing edge bridges the cycle before the countdown loads
  assign icoast = q.vf | pre_on | (q.pcnt != 8'h00) | (vtrail & (q.post != 8'h00));
  assign hpol = q.cctl[CCTL_POVR] ? q.cctl[CCTL_IPOL] : HOLD_AUTO_HIGH;
  assign xcoast = hpol ? hold : ~hold;

  // Clamp terms
  logic iclamp; // Internal clamp window
  logic xclamp; // External clamp active
  assign iclamp = (q.ccnt >= {1'b0, CLAMP_PLACE}) &&
                  (q.ccnt < ({1'b0, CLAMP_PLACE} + {1'b0, CLAMP_DUR}));
  assign xclamp = CLAMP_EXT_HIGH ? cpin : ~cpin;

  // Next-state logic
  always_comb
  begin
    n = q;
    // Two-stage pin synchronisers
    n.m1 = {clamp_pin_i, hold_pin_i, sep_vsync_i, vsync_pin_i};
    n.m2 = q.m1;
    // One wait cycle per request
    n.wreq = ~(req & q.wreq);
    if (req && q.wreq)
    begin
      case (idx)
        IDX_HCTL: n.rdata = q.hctl;
        IDX_HLEN: n.rdata = q.hlen;
        IDX_VCTL: n.rdata = q.vctl;
        IDX_VLEN: n.rdata = q.vlen;
        IDX_PRE: n.rdata = q.pre;
        IDX_POST: n.rdata = q.post;
        IDX_CCTL: n.rdata = q.cctl;
        IDX_STAT: n.rdata = {3'h0, alive, q.clamp, q.coast, phigh, q.vout};
        default: n.rdata = 8'h00; // Unmapped reads zero
      endcase
    end
    // Writes land at the acknowledge edge
    if (wr_en)
    begin
      case (idx)
        IDX_HCTL: n.hctl = avs_writedata_i[7:0] & HCTL_MASK;
        IDX_HLEN: n.hlen = avs_writedata_i[7:0];
        IDX_VCTL: n.vctl = avs_writedata_i[7:0] & VCTL_MASK;
        IDX_VLEN: n.vlen = avs_writedata_i[7:0];
        IDX_PRE: n.pre = avs_writedata_i[7:0];
        IDX_POST: n.post = avs_writedata_i[7:0];
        IDX_CCTL: n.cctl = avs_writedata_i[7:0] & CCTL_MASK;
        default: n.rdata = q.rdata; // Unmapped writes ignored
      endcase
    end
    // Pin activity watchdog
    n.pinp = pin;
    if (pin != q.pinp)
    begin
      n.idle = '0;
    end
    else if (alive)
    begin
      n.idle = q.idle + CNT_W'(1);
    end
    // Level run measurement for polarity
    n.vprev = vsel;
    if (vsel != q.vprev)
    begin
      if (q.vprev)
      begin
        n.hi_len = q.run;
      end
      else
      begin
        n.lo_len = q.run;
      end
      n.run = '0;
    end
    else if (q.run != '1)
    begin
      n.run = q.run + CNT_W'(1);
    end
    // Filter resamples at line strobe only
    n.vfp = q.vf;
    if (q.vctl[VCTL_FILT])
    begin
      if (line_strobe_i)
      begin
        n.vf = vact;
      end
    end
    else
    begin
      n.vf = vact;
    end
    // Duration stage
    if (!q.vctl[VCTL_DEN])
    begin
      n.vout = q.vf;
      n.vdc = 8'h00;
    end
    else if (vlead)
    begin
      n.vout = 1'b1;
      n.vdc = q.vlen;
    end
    else if (line_strobe_i && q.vout)
    begin
      if (q.vdc <= 8'h01)
      begin
        n.vout = 1'b0;
        n.vdc = 8'h00;
      end
      else
      begin
        n.vdc = q.vdc - 8'h01;
      end
    end
    // Frame line counting for precoast
    if (vlead)
    begin
      n.flines = q.lcnt;
      n.lcnt = '0;
    end
    else if (line_strobe_i && q.lcnt != '1)
    begin
      n.lcnt = q.lcnt + LINE_W'(1);
    end
    // Postcoast countdown
    if (vtrail)
    begin
      n.pcnt = q.post;
    end
    else if (line_strobe_i && q.pcnt != 8'h00)
    begin
      n.pcnt = q.pcnt - 8'h01;
    end
    // Hold source select
    n.coast = q.cctl[CCTL_CSRC] ? xcoast : icoast;
    // Hsync pulse generator
    if (line_strobe_i && q.hlen != 8'h00)
    begin
      n.hs_act = 1'b1;
      n.hcnt = 8'h01;
    end
    else if (q.hs_act)
    begin
      if (q.hcnt >= q.hlen)
      begin
        n.hs_act = 1'b0;
      end
      else
      begin
        n.hcnt = q.hcnt + 8'h01;
      end
    end
    n.hs = q.hctl[HCTL_OPOL] ? q.hs_act : ~q.hs_act;
    n.vs = q.vctl[VCTL_OPOL] ? q.vout : ~q.vout;
    // Clamp pixel counter from line start
    if (line_strobe_i)
    begin
      n.ccnt = 9'h000;
    end
    else if (q.ccnt != 9'h1ff)
    begin
      n.ccnt = q.ccnt + 9'h001;
    end
    n.clamp = q.cctl[CCTL_CLSRC] ? xclamp : iclamp;
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      q <= '0;
      q.wreq <= 1'b1;
      q.hctl <= HCTL_RST;
      q.hlen <= HLEN_RST;
      q.vctl <= VCTL_RST;
      q.vlen <= VLEN_RST;
      q.pre <= PRE_RST;
      q.post <= POST_RST;
      q.cctl <= CCTL_RST;
      q.hs <= 1'b1;
      q.vs <= 1'b1;
    end
    else
    begin
      q <= n;
    end
  end

  // Outputs straight from state
  assign avs_readdata_o = {24'h000000, q.rdata};
  assign avs_waitrequest_o = q.wreq;
  assign hsync_o = q.hs;
  assign vsync_o = q.vs;
  assign coast_o = q.coast;
  assign clamp_o = q.clamp;
  assign red_mid_o = q.cctl[CCTL_RED];
  assign green_mid_o = q.cctl[CCTL_GRN];

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  property p_hs_pol;
    nrst_i |=> hsync_o == ($past(q.hctl[HCTL_OPOL]) ? $past(q.hs_act) : !$past(q.hs_act));
  endproperty
  a_hs_pol: assert property (p_hs_pol) else $error("hsync polarity wrong");

  property p_hctl_keep;
    !(wr_en && idx == IDX_HCTL) |=> $stable(q.hctl);
  endproperty
  a_hctl_keep: assert property (p_hctl_keep) else $error("hsync control changed");

  property p_hs_end;
    q.hs_act && q.hcnt == q.hlen && !line_strobe_i |=> !q.hs_act;
  endproperty
  a_hs_end: assert property (p_hs_end) else $error("hsync pulse too long");

  property p_hs_start;
    line_strobe_i && q.hlen > 8'h01 |=> q.hs_act && q.hcnt == 8'h01 ##1 q.hs_act;
  endproperty
  a_hs_start: assert property (p_hs_start) else $error("hsync pulse not started");

  property p_vsrc;
    q.vctl[VCTL_SOVR] && q.vctl[VCTL_POVR] && !q.vctl[VCTL_FILT]
      |=> q.vf == ($past(q.vctl[VCTL_IPOL]) ~^ ($past(q.vctl[VCTL_SRC]) ? $past(sep) : $past(pin)));
  endproperty
  a_vsrc: assert property (p_vsrc) else $error("vsync source or polarity wrong");

  property p_vs_out;
    nrst_i |=> vsync_o == ($past(q.vctl[VCTL_OPOL]) ? $past(q.vout) : !$past(q.vout));
  endproperty
  a_vs_out: assert property (p_vs_out) else $error("vsync output polarity wrong");

  property p_filt;
    q.vctl[VCTL_FILT] && !line_strobe_i |=> $stable(q.vf);
  endproperty
  a_filt: assert property (p_filt) else $error("filtered vsync moved off strobe");

  property p_vdur_off;
    !q.vctl[VCTL_DEN] |=> q.vout == $past(q.vf);
  endproperty
  a_vdur_off: assert property (p_vdur_off) else $error("vsync width altered");

  property p_vdur_end;
    q.vctl[VCTL_DEN] && q.vout && line_strobe_i && q.vdc <= 8'h01 && !vlead |=> !q.vout;
  endproperty
  a_vdur_end: assert property (p_vdur_end) else $error("vsync duration overrun");

  property p_pre;
    pre_on && !q.cctl[CCTL_CSRC] |=> coast_o;
  endproperty
  a_pre: assert property (p_pre) else $error("precoast missing");

  property p_post;
    vtrail && q.post != 8'h00 && !q.cctl[CCTL_CSRC] |=> ##1 coast_o;
  endproperty
  a_post: assert property (p_post) else $error("postcoast missing");

  property p_xcoast;
    q.cctl[CCTL_CSRC] && q.cctl[CCTL_POVR]
      |=> coast_o == ($past(q.cctl[CCTL_IPOL]) ? $past(hold) : !$past(hold));
  endproperty
  a_xcoast: assert property (p_xcoast) else $error("external hold wrong");

  property p_xclamp;
    q.cctl[CCTL_CLSRC] |=> clamp_o == $past(xclamp);
  endproperty
  a_xclamp: assert property (p_xclamp) else $error("external clamp wrong");

  property p_lvl;
    wr_en && idx == IDX_CCTL |=> red_mid_o == $past(avs_writedata_i[CCTL_RED]) &&
                                 green_mid_o == $past(avs_writedata_i[CCTL_GRN]);
  endproperty
  a_lvl: assert property (p_lvl) else $error("clamp level not stored");

  c_hs: cover property (line_strobe_i && q.hlen != 8'h00 ##1 q.hs_act);
  c_pre: cover property (pre_on && !q.vf);
  c_vdur: cover property (q.vctl[VCTL_DEN] && $fell(q.vout));
  c_xhold: cover property (q.cctl[CCTL_CSRC] && $rose(coast_o));

endmodule : scc_sync_ctrl

// *** scc_far_model.sv ***
`timescale 1ns/1ps
// Far side: line strobe source and the four sync pins
module scc_far_model
#(
  parameter int LINE = 40
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] lvl_i,
  output logic line_strobe_o,
  output logic vsync_pin_o,
  output logic sep_vsync_o,
  output logic hold_pin_o,
  output logic clamp_pin_o
);
  // Pixel count within one line
  int cnt;
  // One-cycle strobe once per line period
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt <= 0;
      line_strobe_o <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == LINE - 1) ? 0 : cnt + 1;
      line_strobe_o <= (cnt == LINE - 1);
    end
  end
  // Pins take the requested levels one edge later
  always_ff @(posedge clk_i)
  begin
    vsync_pin_o <= lvl_i[0];
    sep_vsync_o <= lvl_i[1];
    hold_pin_o <= lvl_i[2];
    clamp_pin_o <= lvl_i[3];
  end
endmodule : scc_far_model

// *** tb_scc_sync_ctrl.sv ***
`timescale 1ns/1ps
// Register and sync-output tests through the Avalon port
module tb_scc_sync_ctrl
  import scc_pkg::*;
;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wait_r;
  logic [3:0] lvl = 4'h0;
  logic ls, vp, sp, hp, cp;
  logic hs, vs, co, cl, rm, gm;
  int failures = 0;
  int checks_done = 0;
  // Reset values for indices 0x12..0x18
  logic [7:0] rst_tab [7] = '{8'h08, 8'h20, 8'h18, 8'h0a, 8'h00, 8'h00, 8'h20};
  logic [7:0] got;
  int n;
  localparam int LINE_CYC = 40; // Pixels per line in the far model

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  scc_sync_ctrl #(.VS_IDLE(64)) DUT (
    .clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'h1),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_r), .line_strobe_i(ls),
    .vsync_pin_i(vp), .sep_vsync_i(sp), .hold_pin_i(hp), .clamp_pin_i(cp),
    .hsync_o(hs), .vsync_o(vs), .coast_o(co), .clamp_o(cl),
    .red_mid_o(rm), .green_mid_o(gm)
  );

  scc_far_model #(.LINE(LINE_CYC)) far (
    .clk_i(clk_i), .nrst_i(nrst_i), .lvl_i(lvl), .line_strobe_o(ls),
    .vsync_pin_o(vp), .sep_vsync_o(sp), .hold_pin_o(hp), .clamp_pin_o(cp)
  );

  // Verdict and end of run
  task automatic final_report();
    $display("Counts: %0d checks, %0d mismatches", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  // Byte compare
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  // Avalon write, held until waitrequest is seen low
  task automatic bus_wr(input logic [5:0] idx, input logic [7:0] d);
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    wr <= 1'b1;
    do
    begin
      @(posedge clk_i);
    end
    while (wait_r !== 1'b0);
    wr <= 1'b0;
    @(posedge clk_i);
  endtask : bus_wr

  // Avalon read, data taken at the acknowledge edge
  task automatic bus_rd(input logic [5:0] idx, output logic [7:0] d);
    adr <= {idx, 2'b00};
    rd <= 1'b1;
    do
    begin
      @(posedge clk_i);
    end
    while (wait_r !== 1'b0);
    d = rdat[7:0];
    rd <= 1'b0;
    @(posedge clk_i);
  endtask : bus_rd

  // Wait a bounded time for an output to reach a level
  task automatic out_is(input int w, input logic e, input string m);
    logic [5:0] o;
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clk_i);
      o = {gm, rm, cl, co, vs, hs};
      if (o[w] === e)
        break;
    end
    chk({7'h0, o[w]}, {7'h0, e}, m);
  endtask : out_is

  // Measure one active width of an output at a given level
  task automatic out_width(input int w, input logic pol, output int cnt);
    logic [5:0] o;
    cnt = 0;
    o = {gm, rm, cl, co, vs, hs};
    for (int i = 0; i < 100 && o[w] !== pol; i++)
    begin
      @(posedge clk_i);
      o = {gm, rm, cl, co, vs, hs};
    end
    for (int i = 0; i < 100 && o[w] === pol; i++)
    begin
      @(posedge clk_i);
      o = {gm, rm, cl, co, vs, hs};
      cnt++;
    end
  endtask : out_width

  // Watchdog
  initial
  begin
    #200000;
    failures++;
    $display("BAD %0t watchdog expired", $time);
    final_report();
  end

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 7; i++)
    begin
      bus_rd(IDX_HCTL + 6'(i), got);
      chk(got, rst_tab[i], "reset value");
    end
    bus_rd(6'h00, got);
    chk(got, 8'h00, "unmapped read");
    $display("test reset values done");
    // Writable masks and read-back
    bus_wr(IDX_HCTL, 8'hff);
    bus_rd(IDX_HCTL, got);
    chk(got, 8'h08, "hctl mask");
    bus_wr(IDX_VCTL, 8'hff);
    bus_rd(IDX_VCTL, got);
    chk(got, 8'hfe, "vctl mask");
    bus_wr(IDX_CCTL, 8'hff);
    bus_rd(IDX_CCTL, got);
    chk(got, 8'hfc, "cctl mask");
    bus_wr(IDX_VLEN, 8'h5a);
    bus_rd(IDX_VLEN, got);
    chk(got, 8'h5a, "vlen rw");
    $display("test masks done");
    // Hsync width in pixels at both polarities
    bus_wr(IDX_HLEN, 8'h03);
    out_width(0, 1'b1, n);
    out_width(0, 1'b1, n);
    chk(8'(n), 8'h03, "hsync width high");
    bus_wr(IDX_HCTL, 8'h00);
    out_width(0, 1'b0, n);
    out_width(0, 1'b0, n);
    chk(8'(n), 8'h03, "hsync width low");
    $display("test hsync done");
    // Vsync from pin and separator under polarity override, filter and duration off
    bus_wr(IDX_VCTL, 8'hb8);
    lvl <= 4'h1;
    out_is(1, 1'b1, "vsync active high");
    lvl <= 4'h0;
    out_is(1, 1'b0, "vsync idle");
    bus_wr(IDX_VCTL, 8'ha8);
    out_is(1, 1'b1, "vsync input active low");
    bus_wr(IDX_VCTL, 8'hf8);
    out_is(1, 1'b0, "vsync separator idle");
    lvl <= 4'h2;
    out_is(1, 1'b1, "vsync from separator");
    bus_wr(IDX_VCTL, 8'hb0);
    lvl <= 4'h1;
    out_is(1, 1'b0, "vsync output low");
    $display("test vsync done");
    // Coast from hold pin under polarity override
    bus_wr(IDX_CCTL, 8'he0);
    lvl <= 4'h4;
    out_is(2, 1'b1, "coast pin high");
    lvl <= 4'h0;
    out_is(2, 1'b0, "coast pin released");
    bus_wr(IDX_CCTL, 8'hc0);
    out_is(2, 1'b1, "coast pin low active");
    $display("test coast done");
    // External clamp and clamp levels
    bus_wr(IDX_CCTL, 8'h1c);
    lvl <= 4'h8;
    out_is(3, 1'b1, "clamp pin active");
    out_is(4, 1'b1, "red midscale");
    out_is(5, 1'b1, "green midscale");
    lvl <= 4'h0;
    out_is(3, 1'b0, "clamp pin idle");
    bus_wr(IDX_CCTL, 8'h00);
    out_is(4, 1'b0, "red ground");
    out_is(5, 1'b0, "green ground");
    out_width(3, 1'b1, n);
    out_width(3, 1'b1, n);
    chk(8'(n), CLAMP_DUR_DEF, "internal clamp width");
    $display("test clamp done");
    // Filtered vsync with duration stage, then hold after and before it
    bus_wr(IDX_VCTL, 8'hbe);
    bus_wr(IDX_VLEN, 8'h02);
    bus_wr(IDX_POST, 8'h02);
    lvl <= 4'h1;
    out_width(1, 1'b1, n);
    chk(8'(n > LINE_CYC && n <= 2 * LINE_CYC), 8'h01, "vsync duration");
    lvl <= 4'h0;
    repeat (50) @(posedge clk_i);
    chk({7'h0, co}, 8'h01, "postcoast held");
    out_width(2, 1'b1, n);
    chk(8'(n < 100), 8'h01, "postcoast ends");
    bus_wr(IDX_PRE, 8'hff);
    out_is(2, 1'b1, "precoast window");
    bus_rd(IDX_STAT, got);
    chk(got & 8'h04, 8'h04, "status hold bit");
    $display("test coast window done");
    final_report();
  end
endmodule : tb_scc_sync_ctrl
